// >>> rtl/flash_host_pkg.sv
// Constants, types and timing for the parallel NOR flash host controller.
// Behaviour
// - Write only with select, strobe low, drive high.
// - Exceeded-limit flag high: host writes reset command.
// - Two unlocks plus autoselect command enter autoselect.
// - Only reset command leaves autoselect mode.
// - Program: two unlocks, set-up, address with data.
// - Two unlocks plus 20h enter unlock bypass.
// - Bypass program: A0h then address with data.
// - Bypass refuses program, allows read and bypass program, exit by 90h then 00h.
package flash_host_pkg;

  // Bus timing at the 40 MHz reference clock.
  localparam int CLK_NS    = 25;
  localparam int T_WP_NS   = 35;   // Least write strobe low time.
  localparam int T_WPH_NS  = 30;   // Least strobe high and data hold time.
  localparam int T_ACC_NS  = 70;   // Read access time.
  localparam int T_BUSY_NS = 90;   // Program start to busy output valid.
  localparam int SYNC_CYC  = 2;    // Pin synchroniser latency.
  localparam logic [3:0] WP_CYC   = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WPH_CYC  = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [3:0] BUSY_CYC = 4'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);

  // Command codes and unlock cycles.
  localparam logic [19:0] UNLOCK1_ADDR    = 20'h00001;
  localparam logic [15:0] UNLOCK1_DATA    = 16'h0001;
  localparam logic [19:0] UNLOCK2_ADDR    = 20'h00002;
  localparam logic [15:0] UNLOCK2_DATA    = 16'h0002;
  localparam logic [15:0] CMD_PROGRAM     = 16'h0003;
  localparam logic [15:0] CMD_AUTOSELECT  = 16'h0004;
  localparam logic [15:0] CMD_RESET       = 16'h0005;
  localparam logic [15:0] CMD_BYPASS      = 16'h0020;
  localparam logic [15:0] CMD_BYPASS_PGM  = 16'h00A0;
  localparam logic [15:0] CMD_BYPASS_EXIT = 16'h0090;
  localparam logic [15:0] CMD_BYPASS_END  = 16'h0000;
  localparam int          LIMIT_BIT       = 5;  // Exceeded-limit flag position.

  // User operation codes.
  localparam logic [2:0] OP_READ        = 3'h0;
  localparam logic [2:0] OP_RESET       = 3'h1;
  localparam logic [2:0] OP_AUTOSELECT  = 3'h2;
  localparam logic [2:0] OP_PROGRAM     = 3'h3;
  localparam logic [2:0] OP_BYPASS      = 3'h4;
  localparam logic [2:0] OP_BYPASS_PGM  = 3'h5;
  localparam logic [2:0] OP_BYPASS_EXIT = 3'h6;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_ADDR  = 6'h02,
    S_PULSE = 6'h04,
    S_HOLD  = 6'h08,
    S_READ  = 6'h10,
    S_BUSY  = 6'h20
  } state_t;

  // One bus cycle of a command sequence.
  typedef struct packed {
    logic        rd;
    logic        last;
    logic        poll;
    logic [19:0] a;
    logic [15:0] d;
  } cyc_t;

endpackage

// >>> rtl/pin_sync.sv
// Two-stage synchroniser for flash pins read by the host.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 17
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // Pins and synchronised copy.
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  // The first stage feeds only the second stage.
  always_comb begin
    d    = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.s2;

endmodule // pin_sync
`default_nettype wire

// >>> rtl/nor_flash_host.sv
// Host controller that issues command sequences to a parallel NOR flash.
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // User command port.
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [19:0] cmd_addr,
  input  wire logic [15:0] cmd_data,
  input  wire logic        cmd_byte_mode,
  // User response port.
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_error,
  output logic             bypass_mode,
  output logic             autoselect_mode,
  // Flash pins.
  output logic             chip_select_n,
  output logic             write_strobe_n,
  output logic             output_drive_n,
  output logic             width_select_n,
  output logic [19:0]      flash_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in,
  input  wire logic        ready_busy_n
);

  typedef struct packed {
    flash_host_pkg::state_t st;
    logic [2:0]  op;
    logic [2:0]  step;
    logic [3:0]  cnt;
    logic [19:0] addr;
    logic [15:0] data;
    logic        polling;
    logic        fail;
    logic        bypass;
    logic        autosel;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        byte_n;
    logic [19:0] pin_addr;
    logic [15:0] dq_o;
    logic        dq_e;
    logic        rsp_v;
    logic [15:0] rsp_d;
    logic        rsp_e;
  } host_t;

  host_t q;
  host_t d;
  logic [16:0] synced;
  logic [15:0] dq_s;
  logic        rb_s;
  flash_host_pkg::cyc_t cur;

  // Pins from the device are asynchronous to ref_clk.
  pin_sync #(.W(17)) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin_in  ({ready_busy_n, dq_in}),
    .pin_out (synced)
  );
  assign dq_s = synced[15:0];
  assign rb_s = synced[16];

  // Bus cycle table for each operation and step.
  function automatic flash_host_pkg::cyc_t cycle(input logic [2:0] op, input logic [2:0] step,
                                                 input logic [19:0] a, input logic [15:0] dt);
    flash_host_pkg::cyc_t c;
    c = '{rd: 1'b0, last: 1'b0, poll: 1'b0, a: 20'h00000, d: 16'h0000};
    case (op)
      flash_host_pkg::OP_READ: begin
        c.rd = 1'b1;
        c.last = 1'b1;
        c.a = a;
      end
      flash_host_pkg::OP_RESET: begin
        c.last = 1'b1;
        c.d = flash_host_pkg::CMD_RESET;
      end
      flash_host_pkg::OP_BYPASS_PGM: begin
        c.last = (step == 3'h1);
        c.poll = c.last;
        c.a = c.last ? a : 20'h00000;
        c.d = c.last ? dt : flash_host_pkg::CMD_BYPASS_PGM;
      end
      flash_host_pkg::OP_BYPASS_EXIT: begin
        c.last = (step == 3'h1);
        c.d = c.last ? flash_host_pkg::CMD_BYPASS_END : flash_host_pkg::CMD_BYPASS_EXIT;
      end
      default: begin
        // Unlock-prefixed sequences: two unlocks, then a command, then for program the target.
        c.last = (op == flash_host_pkg::OP_PROGRAM) ? (step == 3'h3) : (step == 3'h2);
        c.poll = (op == flash_host_pkg::OP_PROGRAM) && c.last;
        case (step)
          3'h0: begin
            c.a = flash_host_pkg::UNLOCK1_ADDR;
            c.d = flash_host_pkg::UNLOCK1_DATA;
          end
          3'h1: begin
            c.a = flash_host_pkg::UNLOCK2_ADDR;
            c.d = flash_host_pkg::UNLOCK2_DATA;
          end
          3'h2: begin
            c.a = flash_host_pkg::UNLOCK1_ADDR;
            if (op == flash_host_pkg::OP_PROGRAM) begin
              c.d = flash_host_pkg::CMD_PROGRAM;
            end else if (op == flash_host_pkg::OP_AUTOSELECT) begin
              c.d = flash_host_pkg::CMD_AUTOSELECT;
            end else begin
              c.d = flash_host_pkg::CMD_BYPASS;
            end
          end
          default: begin
            c.a = a;
            c.d = dt;
          end
        endcase
      end
    endcase
    return c;
  endfunction

  // Decide whether an operation fits the device's current mode.
  function automatic logic allowed(input logic [2:0] op, input logic byp, input logic asel);
    logic ok;
    ok = 1'b0;
    if (byp) begin
      ok = (op == flash_host_pkg::OP_READ) || (op == flash_host_pkg::OP_BYPASS_PGM) ||
           (op == flash_host_pkg::OP_BYPASS_EXIT);
    end else if (asel) begin
      ok = (op == flash_host_pkg::OP_READ) || (op == flash_host_pkg::OP_RESET);
    end else begin
      ok = (op <= flash_host_pkg::OP_BYPASS);
    end
    return ok;
  endfunction

  assign cur = cycle(q.op, q.step, q.addr, q.data);

  // Sequencer: each write step is setup, strobe low, strobe high with hold, then select released.
  always_comb begin
    d       = q;
    d.rsp_v = 1'b0;
    case (q.st)
      flash_host_pkg::S_IDLE: begin
        if (cmd_valid) begin
          d.op      = cmd_op;
          d.addr    = cmd_addr;
          d.data    = cmd_data;
          d.byte_n  = ~cmd_byte_mode;
          d.step    = 3'h0;
          d.polling = 1'b0;
          d.fail    = 1'b0;
          if (allowed(cmd_op, q.bypass, q.autosel)) begin
            d.st = flash_host_pkg::S_ADDR;
          end else begin
            d.rsp_v = 1'b1;
            d.rsp_e = 1'b1;
          end
        end
      end
      flash_host_pkg::S_ADDR: begin
        // Address and select settle one cycle before any strobe, so the device's
        // address latch at the later falling edge never sees the bus moving.
        if (q.ce_n) begin
          d.ce_n     = 1'b0;
          d.pin_addr = q.polling ? q.addr : cur.a;
          d.dq_o     = cur.d;
        end else if (q.polling || cur.rd) begin
          d.oe_n = 1'b0;
          d.cnt  = flash_host_pkg::RD_CYC;
          d.st   = flash_host_pkg::S_READ;
        end else begin
          d.dq_e = 1'b1;
          d.we_n = 1'b0;
          d.cnt  = flash_host_pkg::WP_CYC;
          d.st   = flash_host_pkg::S_PULSE;
        end
      end
      flash_host_pkg::S_PULSE: begin
        if (q.cnt <= 4'h1) begin
          d.we_n = 1'b1;
          d.cnt  = flash_host_pkg::WPH_CYC;
          d.st   = flash_host_pkg::S_HOLD;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      flash_host_pkg::S_HOLD: begin
        if (q.cnt > 4'h1) begin
          d.cnt = q.cnt - 4'h1;
        end else if (!q.ce_n) begin
          // Data stays driven until select rises, so both latch edges see it.
          d.ce_n = 1'b1;
          d.dq_e = 1'b0;
        end else if (!cur.last) begin
          d.step = q.step + 3'h1;
          d.st   = flash_host_pkg::S_ADDR;
        end else if (cur.poll) begin
          d.cnt = flash_host_pkg::BUSY_CYC;
          d.st  = flash_host_pkg::S_BUSY;
        end else begin
          d.st    = flash_host_pkg::S_IDLE;
          d.rsp_v = 1'b1;
          d.rsp_e = q.fail;
          case (q.op)
            flash_host_pkg::OP_RESET:       d.autosel = 1'b0;
            flash_host_pkg::OP_AUTOSELECT:  d.autosel = 1'b1;
            flash_host_pkg::OP_BYPASS:      d.bypass  = 1'b1;
            flash_host_pkg::OP_BYPASS_EXIT: d.bypass  = 1'b0;
            default:                        d.bypass  = q.bypass;
          endcase
        end
      end
      flash_host_pkg::S_BUSY: begin
        // No command is written while the device programs; only status reads.
        if (q.cnt <= 4'h1) begin
          d.polling = 1'b1;
          d.st      = flash_host_pkg::S_ADDR;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      flash_host_pkg::S_READ: begin
        if (q.cnt <= 4'h1) begin
          d.ce_n  = 1'b1;
          d.oe_n  = 1'b1;
          d.rsp_d = dq_s;
          if (!q.polling || rb_s) begin
            d.st    = flash_host_pkg::S_IDLE;
            d.rsp_v = 1'b1;
            d.rsp_e = 1'b0;
          end else if (dq_s[flash_host_pkg::LIMIT_BIT]) begin
            // Failed program: a reset command brings the device back to array reads.
            d.fail    = 1'b1;
            d.polling = 1'b0;
            d.op      = flash_host_pkg::OP_RESET;
            d.step    = 3'h0;
            d.st      = flash_host_pkg::S_ADDR;
          end else begin
            d.cnt = flash_host_pkg::BUSY_CYC;
            d.st  = flash_host_pkg::S_BUSY;
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        d = q;
        d.st = flash_host_pkg::S_IDLE;
      end
    endcase
  end

  // Strobes reset inactive so power-up never looks like a write.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q        <= '0;
      q.st     <= flash_host_pkg::S_IDLE;
      q.ce_n   <= 1'b1;
      q.we_n   <= 1'b1;
      q.oe_n   <= 1'b1;
      q.byte_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready       = (q.st == flash_host_pkg::S_IDLE);
  assign rsp_valid       = q.rsp_v;
  assign rsp_data        = q.rsp_d;
  assign rsp_error       = q.rsp_e;
  assign bypass_mode     = q.bypass;
  assign autoselect_mode = q.autosel;
  assign chip_select_n   = q.ce_n;
  assign write_strobe_n  = q.we_n;
  assign output_drive_n  = q.oe_n;
  assign width_select_n  = q.byte_n;
  assign flash_addr      = q.pin_addr;
  assign dq_out          = q.dq_o;
  assign dq_oe           = q.dq_e;

endmodule // nor_flash_host
`default_nettype wire

// >>> sim/nor_flash_host_asserts.sv
// Concurrent checks on the ports of the flash host controller.
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host_asserts (
  // Clock, reset and user port.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_ready,
  input  wire logic [2:0]  cmd_op,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic        bypass_mode,
  input  wire logic        autoselect_mode,
  // Flash pins.
  input  wire logic        chip_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_drive_n,
  input  wire logic [19:0] flash_addr,
  input  wire logic        dq_oe
);
  logic take;
  // A request counts as taken on an edge with valid and ready both high.
  assign take = cmd_valid && cmd_ready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  reset_idle_a: assert property (
    $rose(reset_n) |-> chip_select_n && write_strobe_n && !dq_oe
  ) else $error("Pins active after reset.");
  write_qual_a: assert property (
    !write_strobe_n |-> !chip_select_n && output_drive_n
  ) else $error("Strobe low outside a qualified write.");
  drive_clash_a: assert property (
    !output_drive_n |-> !dq_oe
  ) else $error("Host drives data while device output is on.");
  addr_hold_a: assert property (
    !chip_select_n && $past(!chip_select_n) |-> $stable(flash_addr)
  ) else $error("Address moved while selected.");
  addr_setup_a: assert property (
    $fell(write_strobe_n) |-> $past(!chip_select_n) && $stable(flash_addr)
  ) else $error("Address not set up before strobe fall.");
  strobe_width_a: assert property (
    $fell(write_strobe_n) |-> (!write_strobe_n) [*2] ##1 write_strobe_n
  ) else $error("Write strobe width wrong.");
  data_hold_a: assert property (
    $rose(write_strobe_n) |-> (dq_oe && !chip_select_n) [*2] ##1 (chip_select_n && !dq_oe)
  ) else $error("Data not held after strobe rise.");
  bypass_refuse_a: assert property (
    take && bypass_mode && cmd_op == flash_host_pkg::OP_PROGRAM |-> ##[1:2] rsp_valid && rsp_error
  ) else $error("Program in bypass not refused.");
  auto_refuse_a: assert property (
    take && autoselect_mode && cmd_op == flash_host_pkg::OP_PROGRAM
      |-> chip_select_n throughout (##[1:2] (rsp_valid && rsp_error))
  ) else $error("Program in autoselect not refused.");
  auto_enter_a: assert property (
    take && !autoselect_mode && !bypass_mode && cmd_op == flash_host_pkg::OP_AUTOSELECT
      |-> ##[1:40] autoselect_mode
  ) else $error("Autoselect mode not entered.");
  bypass_exit_a: assert property (
    take && bypass_mode && cmd_op == flash_host_pkg::OP_BYPASS_EXIT |-> ##[1:40] !bypass_mode
  ) else $error("Bypass mode not left.");
endmodule // nor_flash_host_asserts
bind nor_flash_host nor_flash_host_asserts u_chk (
  .ref_clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .rsp_error, .bypass_mode,
  .autoselect_mode, .chip_select_n, .write_strobe_n, .output_drive_n, .flash_addr, .dq_oe
);
`default_nettype wire

// >>> sim/flash_device_model.sv
// Behavioural model of the parallel NOR flash command state machine.
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
  parameter logic [15:0] MFR_ID  = 16'h00C3, // Arbitrary value.
  parameter logic [15:0] DEV_ID  = 16'h2A5B, // Arbitrary value.
  parameter int          BUSY_NS = 400
) (
  // Supply monitor and control pins.
  input  wire logic        supply_ok,
  input  wire logic        chip_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_drive_n,
  input  wire logic        width_select_n,
  // Address and data pins.
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] dq_bus,
  output logic      [15:0] dq_drv,
  output logic             ready_busy_n
);
  logic [15:0] mem [16];
  logic [15:0] pd, m, val, last;
  logic [19:0] wa;
  logic [7:0]  d;
  logic [2:0]  st;
  logic        lim, tog, wr, drv;
  // A write needs select and strobe low, drive high and a good supply.
  assign wr  = supply_ok && !chip_select_n && !write_strobe_n && output_drive_n;
  assign drv = !chip_select_n && !output_drive_n;
  assign d   = dq_bus[7:0];
  // Power-up lands in array read with an erased array.
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    st = 3'h0;
    lim = 1'b0;
    tog = 1'b0;
    pd = 16'h0000;
    // A defined address keeps the time-zero fall of the write qualifier harmless.
    wa = 20'h00000;
    last = 16'h0000;
    ready_busy_n = 1'b1;
  end
  // Program clears bits only; a one over a zero raises the limit flag.
  task automatic pgm(input logic [2:0] nx);
    m = width_select_n ? 16'hFFFF : 16'h00FF;
    pd = dq_bus | ~m;
    lim = |(pd & ~mem[wa[3:0]]);
    mem[wa[3:0]] = mem[wa[3:0]] & pd;
    ready_busy_n = 1'b0;
    st = nx;
  endtask
  always @(posedge wr) wa = flash_addr;
  // Commands decode as data latches; busy ignores all but reset on a limit fault.
  always @(negedge wr) begin
    if (!ready_busy_n) begin
      if (lim && d == flash_host_pkg::CMD_RESET[7:0]) begin
        lim = 1'b0;
        ready_busy_n = 1'b1;
        st = 3'h0;
      end
    end else if (st != 3'h3 && st < 3'h5 && d == flash_host_pkg::CMD_RESET[7:0]) st = 3'h0;
    else case (st)
      3'h0: st = (wa == flash_host_pkg::UNLOCK1_ADDR && d == 8'h01) ? 3'h1 : 3'h0;
      3'h1: st = (wa == flash_host_pkg::UNLOCK2_ADDR && d == 8'h02) ? 3'h2 : 3'h0;
      3'h2: st = d == 8'h03 ? 3'h3 : d == 8'h04 ? 3'h4 : d == 8'h20 ? 3'h5 : 3'h0;
      3'h3: pgm(3'h0);
      3'h4: st = 3'h4;
      3'h5: st = d == 8'hA0 ? 3'h6 : d == 8'h90 ? 3'h7 : 3'h5;
      3'h6: pgm(3'h5);
      default: st = d == 8'h00 ? 3'h0 : 3'h5;
    endcase
  end
  // The algorithm ends after a fixed time unless the limit flag is up.
  always @(negedge ready_busy_n) begin
    #(BUSY_NS);
    if (!lim) ready_busy_n = 1'b1;
  end
  // Status while busy, codes in autoselect, array data otherwise.
  // The upper half of the array counts as a protected sector.
  always_comb begin
    if (!ready_busy_n) val = {8'h00, ~pd[7], tog, lim, 5'h00};
    else if (st != 3'h4) val = mem[flash_addr[3:0]];
    else if (flash_addr[7:0] < 8'h02) val = flash_addr[0] ? DEV_ID : MFR_ID;
    else val = {15'h0000, flash_addr[19] && flash_addr[7:0] == (width_select_n ? 8'h02 : 8'h04)};
  end
  // Released lines show the inverse of the last value so stale data cannot pass.
  always @(drv or val) if (drv) last = val;
  assign dq_drv = drv ? val : ~last;
  always @(posedge output_drive_n) if (!ready_busy_n) tog = ~tog;
  // Supply loss resets the command logic.
  always @(negedge supply_ok) begin
    st = 3'h0;
    lim = 1'b0;
    ready_busy_n = 1'b1;
  end
endmodule // flash_device_model
`default_nettype wire

// >>> sim/nor_flash_host_tb_top.sv
// Self-checking bench for the flash host controller against a device model.
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host_tb_top;
  localparam logic [15:0] MFR_ID = 16'h00C3; // Arbitrary value.
  localparam logic [15:0] DEV_ID = 16'h2A5B; // Arbitrary value.
  typedef struct packed {
    logic [2:0]  op;
    logic [19:0] a;
    logic [15:0] d;
    logic        b;
    logic        e;
  } row_t;
  logic        ref_clk, reset_n, supply_ok, cmd_valid, cmd_ready, cmd_byte_mode;
  logic        rsp_valid, rsp_error, bypass_mode, autoselect_mode, ready_busy_n, dq_oe;
  logic        chip_select_n, write_strobe_n, output_drive_n, width_select_n;
  logic [2:0]  cmd_op;
  logic [19:0] cmd_addr, flash_addr;
  logic [15:0] cmd_data, rsp_data, dq_out, dq_bus, dq_drv;
  int          mismatches, num_checks;
  // Reads carry the expected data in the data field.
  row_t        rows [25] = '{
    '{3'h0, 20'h00003, 16'hFFFF, 1'h0, 1'h0},
    '{3'h3, 20'h00003, 16'h1234, 1'h0, 1'h0},
    '{3'h0, 20'h00003, 16'h1234, 1'h0, 1'h0},
    '{3'h3, 20'h00006, 16'h0055, 1'h1, 1'h0},
    '{3'h0, 20'h00006, 16'hFF55, 1'h0, 1'h0},
    '{3'h2, 20'h00000, 16'h0000, 1'h0, 1'h0},
    '{3'h0, 20'h00000, MFR_ID, 1'h0, 1'h0},
    '{3'h0, 20'h00001, DEV_ID, 1'h0, 1'h0},
    '{3'h0, 20'h80002, 16'h0001, 1'h0, 1'h0},
    '{3'h0, 20'h00002, 16'h0000, 1'h0, 1'h0},
    '{3'h0, 20'h80004, 16'h0001, 1'h1, 1'h0},
    '{3'h3, 20'h00003, 16'h0000, 1'h0, 1'h1},
    '{3'h1, 20'h00000, 16'h0000, 1'h0, 1'h0},
    '{3'h0, 20'h00000, 16'hFFFF, 1'h0, 1'h0},
    '{3'h4, 20'h00000, 16'h0000, 1'h0, 1'h0},
    '{3'h5, 20'h00004, 16'h00F0, 1'h0, 1'h0},
    '{3'h5, 20'h00005, 16'h0F00, 1'h0, 1'h0},
    '{3'h0, 20'h00004, 16'h00F0, 1'h0, 1'h0},
    '{3'h3, 20'h00003, 16'h0000, 1'h0, 1'h1},
    '{3'h6, 20'h00000, 16'h0000, 1'h0, 1'h0},
    '{3'h0, 20'h00005, 16'h0F00, 1'h0, 1'h0},
    '{3'h5, 20'h00005, 16'h0000, 1'h0, 1'h1},
    '{3'h3, 20'h00003, 16'h1235, 1'h0, 1'h1},
    '{3'h0, 20'h00003, 16'h1234, 1'h0, 1'h0},
    '{3'h7, 20'h00000, 16'h0000, 1'h0, 1'h1}
  };
  // The data wire follows whichever party has its driver on.
  assign dq_bus = dq_oe ? dq_out : dq_drv;
  nor_flash_host dut (
    .ref_clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_byte_mode,
    .rsp_valid, .rsp_data, .rsp_error, .bypass_mode, .autoselect_mode, .chip_select_n,
    .write_strobe_n, .output_drive_n, .width_select_n, .flash_addr, .dq_out, .dq_oe,
    .dq_in(dq_bus), .ready_busy_n
  );
  flash_device_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID), .BUSY_NS(400)) u_dev (
    .supply_ok, .chip_select_n, .write_strobe_n, .output_drive_n, .width_select_n,
    .flash_addr, .dq_bus, .dq_drv, .ready_busy_n
  );
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d.", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Issues one request and waits, bounded, for its response pulse.
  task automatic run_op(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d,
                        input logic b);
    int n;
    n = 0;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_byte_mode <= b;
    cmd_valid <= 1'b1;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    // A response that never comes is a failure, not a silent skip.
    if (rsp_valid !== 1'b1) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, rsp_valid, 1'b1);
    end
  endtask
  // Free-running reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // A hang ends the run long after the tests should have finished.
  initial begin
    #2000000;
    mismatches++;
    complete_run;
  end
  // Table cases first, then reset and supply lockout.
  initial begin
    {reset_n, cmd_valid, cmd_byte_mode, cmd_op, cmd_addr, cmd_data} = '0;
    supply_ok = 1'b1;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].a, rows[i].d, rows[i].b);
      if (rows[i].op == 3'h0) chk(rsp_data, rows[i].d);
      chk({15'h0000, rsp_error}, {15'h0000, rows[i].e});
      $display("Row %0d done.", i);
    end
    // A reset in bypass mode puts every pin and mode back to idle.
    run_op(3'h4, 20'h00000, 16'h0000, 1'b0);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({7'h00, chip_select_n, write_strobe_n, output_drive_n, width_select_n, dq_oe,
         cmd_ready, rsp_valid, bypass_mode, autoselect_mode}, 16'h01E8);
    $display("Reset test done.");
    // Writes during supply lockout are lost, so array data comes back.
    reset_n <= 1'b1;
    supply_ok <= 1'b0;
    @(posedge ref_clk);
    run_op(3'h2, 20'h00000, 16'h0000, 1'b0);
    supply_ok <= 1'b1;
    run_op(3'h0, 20'h00000, 16'h0000, 1'b0);
    chk(rsp_data, 16'hFFFF);
    run_op(3'h1, 20'h00000, 16'h0000, 1'b0);
    $display("Lockout test done.");
    complete_run;
  end
endmodule // nor_flash_host_tb_top
`default_nettype wire
